// ### rtl/rxsw_pkg.sv
// Constants and types shared by the receive status word builder
package rxsw_pkg;
  // ==========================================================
  // Register byte offsets on the Wishbone slave
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT_PORT = 4'h4;
  localparam logic [3:0] OFS_INFO = 4'h8;
  localparam logic [3:0] OFS_DUMP = 4'hC;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CTRL_RECEIVE_ENABLE_BIT_BIT = 2;
  localparam int CTRL_PASS_BAD_BIT = 16;
  localparam int INFO_HALTED_BIT = 16;
  localparam int INFO_OVR_BIT = 17;
  localparam int DUMP_BIT = 0;
  // ==========================================================
  // Status word field positions
  localparam int SW_FILT_FAIL = 30;
  localparam int SW_LEN_LSB = 16;
  localparam int SW_LEN_MSB = 29;
  localparam int SW_ERR_SUM = 15;
  localparam int SW_BCAST = 13;
  localparam int SW_LEN_ERR = 12;
  localparam int SW_RUNT = 11;
  localparam int SW_MCAST = 10;
  localparam int SW_TOO_LONG = 7;
  localparam int SW_LATE_COL = 6;
  localparam int SW_FTYPE = 5;
  localparam int SW_WDOG = 4;
  localparam int SW_MII_ERR = 3;
  localparam int SW_DRIBBLE = 2;
  localparam int SW_CRC_ERR = 1;
  // ==========================================================
  // Byte counts and thresholds
  localparam logic [13:0] COLL_WIN_BYTES = 14'h0040;
  localparam logic [13:0] MAX_FRAME_BYTES = 14'h05EE;
  localparam logic [13:0] WDOG_BYTES = 14'h0800;
  localparam logic [13:0] HDR_BYTES = 14'h000E;
  localparam logic [13:0] HDR_FCS_BYTES = 14'h0012;
  localparam logic [13:0] MIN_PAYLOAD = 14'h002E;
  localparam logic [13:0] CNT_MAX = 14'h3FFF;
  localparam logic [15:0] TYPE_MIN = 16'h05DC;
  localparam logic [13:0] DA_LAST = 14'h0005;
  localparam logic [13:0] LT_HI_IDX = 14'h000C;
  localparam logic [13:0] LT_LO_IDX = 14'h000D;
  localparam logic [2:0] DRIB_NIBBLE = 3'h4;
  localparam logic [2:0] DRIB_10M = 3'h3;
  // ==========================================================
  // Receiver sequencing
  typedef enum logic [1:0] {
    RXSW_IDLE,
    RXSW_RECV,
    RXSW_PUSH,
    RXSW_HALTED
  } rxsw_state_t;
endpackage : rxsw_pkg

// ### rtl/rxsw_fifo_if.sv
// Carrier between the status builder and its status FIFO
`timescale 1ns/1ps
interface rxsw_fifo_if #(
  parameter int CNT_W = 5
);
  logic push;
  logic [31:0] push_data;
  logic pop;
  logic flush;
  logic [31:0] head;
  logic full;
  logic empty;
  logic [CNT_W-1:0] count;
  modport producer (output push, push_data, pop, flush, input head, full, empty, count);
  modport store (input push, push_data, pop, flush, output head, full, empty, count);
endinterface : rxsw_fifo_if

// ### rtl/rxsw_stat_fifo.sv
// Receive status FIFO holding whole 32-bit status words
`timescale 1ns/1ps
module rxsw_stat_fifo #(
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  rxsw_fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  logic [31:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] cnt;
  logic do_push;
  logic do_pop;

  assign do_push = f.push && !f.full;
  assign do_pop = f.pop && !f.empty;
  assign f.full = (cnt == CW'(DEPTH));
  assign f.empty = (cnt == '0);
  assign f.head = mem[rd_ptr];
  assign f.count = cnt;

  // ==========================================================
  // Storage; a word is written only in one piece
  always_ff @(posedge clk_i)
  begin
    if (do_push)
    begin
      mem[wr_ptr] <= f.push_data;
    end
  end

  // ==========================================================
  // Pointers and fill level; flush returns them to reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i || f.flush)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      cnt <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (do_push && !do_pop)
      begin
        cnt <= cnt + 1'b1;
      end
      else if (do_pop && !do_push)
      begin
        cnt <= cnt - 1'b1;
      end
    end
  end
endmodule : rxsw_stat_fifo

// ### rtl/rxsw_builder.sv
// Receive status word builder with receiver stop/start control
// Behaviour
// - One status word per frame after data.
// - Bits 31, 14, 9:8, 0 read zero.
// - Bit 30 marks address filter failure.
// - Bits 29:16 hold frame byte count.
// - Bit 15 is OR of 11,7,6,1.
// - Bit 13 marks broadcast destination.
// - Bit 12 marks length/type mismatch.
// - Bit 11 marks runt below 64 bytes.
// - Runts kept only when pass-bad set.
// - Bit 10 marks multicast destination.
// - Bit 7 above 1518 bytes, no truncation.
// - Bit 6 marks late collision.
// - Bit 5 type above 1500, not short runts.
// - Bit 4 marks receive watchdog expiry.
// - Bit 3 marks RX_ER during frame.
// - Bit 2 dribble: 4 nibble, 3 at 10M.
// - Dribble suppressed by late collision.
// - Bit 1 on FCS mismatch or RX_ER.
// - Single halted pulse once receiver stops.
//
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module rxsw_builder #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic frame_start_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  input wire logic rx_er_i,
  input wire logic collision_i,
  input wire logic frame_end_i,
  input wire logic crc_ok_i,
  input wire logic filter_fail_i,
  input wire logic [2:0] extra_bits_i,
  input wire logic mode_10m_i,
  output logic rx_gate_o,
  output logic receiver_halted_pulse_o
);
  localparam int CNT_W = $clog2(FIFO_DEPTH) + 1;

  rxsw_fifo_if #(.CNT_W(CNT_W)) sf ();

  rxsw_stat_fifo #(
    .DEPTH(FIFO_DEPTH)
  ) u_stat_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .f(sf.store)
  );

  // ==========================================================
  // Declarations
  rxsw_pkg::rxsw_state_t state;
  rxsw_pkg::rxsw_state_t next_state;
  logic [31:0] mac_control_reg;
  logic receive_enable_bit;
  logic pass_bad;
  logic [13:0] byte_cnt;
  logic da_all_ff;
  logic da_group;
  logic [15:0] len_type;
  logic rxer_seen;
  logic late_col;
  logic wdog_hit;
  logic [31:0] word_q;
  logic keep_q;
  logic [31:0] next_word;
  logic runt;
  logic bus_req;
  logic wr_req;
  logic rd_req;
  logic overrun;
  logic flush_q;
  logic push_blocked;

  assign receive_enable_bit = mac_control_reg[rxsw_pkg::CTRL_RECEIVE_ENABLE_BIT_BIT];
  assign pass_bad = mac_control_reg[rxsw_pkg::CTRL_PASS_BAD_BIT];
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_req = bus_req && wb_we_i;
  assign rd_req = bus_req && !wb_we_i;
  assign runt = byte_cnt < rxsw_pkg::COLL_WIN_BYTES;
  assign push_blocked = (state == rxsw_pkg::RXSW_PUSH) && keep_q && sf.full;

  // Apply byte enables to one register word
  function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_sel

  // ==========================================================
  // Status word assembled from the finished frame
  always_comb
  begin
    logic [13:0] payload;
    logic too_long;
    logic crc_err;
    logic len_err;
    logic ftype;
    logic dribble;
    payload = (byte_cnt >= rxsw_pkg::HDR_FCS_BYTES) ?
              byte_cnt - rxsw_pkg::HDR_FCS_BYTES : 14'h0000;
    too_long = byte_cnt > rxsw_pkg::MAX_FRAME_BYTES;
    crc_err = !crc_ok_i || rxer_seen || rx_er_i;
    // Short frames shorter than a header carry no type field
    ftype = (byte_cnt >= rxsw_pkg::HDR_BYTES) && (len_type > rxsw_pkg::TYPE_MIN);
    // Padded frames may carry a length below their real payload
    len_err = 1'b0;
    if ((byte_cnt >= rxsw_pkg::HDR_BYTES) && !ftype)
    begin
      if (payload > rxsw_pkg::MIN_PAYLOAD)
      begin
        len_err = len_type != {2'b00, payload};
      end
      else
      begin
        len_err = len_type > {2'b00, rxsw_pkg::MIN_PAYLOAD};
      end
    end
    dribble = mode_10m_i ? (extra_bits_i >= rxsw_pkg::DRIB_10M) :
              (extra_bits_i >= rxsw_pkg::DRIB_NIBBLE);
    next_word = 32'h0000_0000;
    next_word[rxsw_pkg::SW_FILT_FAIL] = filter_fail_i;
    next_word[rxsw_pkg::SW_LEN_MSB:rxsw_pkg::SW_LEN_LSB] = byte_cnt;
    next_word[rxsw_pkg::SW_BCAST] = da_all_ff;
    next_word[rxsw_pkg::SW_LEN_ERR] = len_err;
    next_word[rxsw_pkg::SW_RUNT] = runt;
    next_word[rxsw_pkg::SW_MCAST] = da_group;
    next_word[rxsw_pkg::SW_TOO_LONG] = too_long;
    next_word[rxsw_pkg::SW_LATE_COL] = late_col;
    next_word[rxsw_pkg::SW_FTYPE] = ftype;
    next_word[rxsw_pkg::SW_WDOG] = wdog_hit;
    next_word[rxsw_pkg::SW_MII_ERR] = rxer_seen || rx_er_i;
    next_word[rxsw_pkg::SW_DRIBBLE] = dribble && !late_col;
    next_word[rxsw_pkg::SW_CRC_ERR] = crc_err;
    next_word[rxsw_pkg::SW_ERR_SUM] = runt || too_long || late_col || crc_err;
  end

  // ==========================================================
  // Receiver sequencing
  always_comb
  begin
    next_state = state;
    case (state)
      rxsw_pkg::RXSW_IDLE:
      begin
        if (!receive_enable_bit)
        begin
          next_state = rxsw_pkg::RXSW_HALTED;
        end
        else if (frame_start_i)
        begin
          next_state = rxsw_pkg::RXSW_RECV;
        end
      end
      rxsw_pkg::RXSW_RECV:
      begin
        // A frame in progress always completes, even once disabled
        if (frame_end_i)
        begin
          next_state = rxsw_pkg::RXSW_PUSH;
        end
      end
      rxsw_pkg::RXSW_PUSH:
      begin
        next_state = rxsw_pkg::RXSW_IDLE;
      end
      rxsw_pkg::RXSW_HALTED:
      begin
        if (receive_enable_bit)
        begin
          next_state = rxsw_pkg::RXSW_IDLE;
        end
      end
      default:
      begin
        next_state = rxsw_pkg::RXSW_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= rxsw_pkg::RXSW_IDLE;
      rx_gate_o <= 1'b0;
      receiver_halted_pulse_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      rx_gate_o <= next_state == rxsw_pkg::RXSW_RECV;
      receiver_halted_pulse_o <= (state == rxsw_pkg::RXSW_IDLE) &&
                                 (next_state == rxsw_pkg::RXSW_HALTED);
    end
  end

  // ==========================================================
  // Per-frame byte counting and address/type capture
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (state == rxsw_pkg::RXSW_IDLE && frame_start_i))
    begin
      byte_cnt <= 14'h0000;
      da_all_ff <= 1'b1;
      da_group <= 1'b0;
      len_type <= 16'h0000;
      wdog_hit <= 1'b0;
    end
    else if (state == rxsw_pkg::RXSW_RECV && byte_valid_i)
    begin
      // Counter saturates instead of wrapping on giant frames
      if (byte_cnt != rxsw_pkg::CNT_MAX)
      begin
        byte_cnt <= byte_cnt + 14'h0001;
      end
      if (byte_cnt <= rxsw_pkg::DA_LAST && byte_i != 8'hFF)
      begin
        da_all_ff <= 1'b0;
      end
      if (byte_cnt == 14'h0000)
      begin
        da_group <= byte_i[0];
      end
      if (byte_cnt == rxsw_pkg::LT_HI_IDX)
      begin
        len_type[15:8] <= byte_i;
      end
      if (byte_cnt == rxsw_pkg::LT_LO_IDX)
      begin
        len_type[7:0] <= byte_i;
      end
      if (byte_cnt >= rxsw_pkg::WDOG_BYTES)
      begin
        wdog_hit <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Error conditions seen during the frame
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (state == rxsw_pkg::RXSW_IDLE && frame_start_i))
    begin
      rxer_seen <= 1'b0;
      late_col <= 1'b0;
    end
    else if (state == rxsw_pkg::RXSW_RECV)
    begin
      if (rx_er_i)
      begin
        rxer_seen <= 1'b1;
      end
      if (collision_i && !runt)
      begin
        late_col <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Word capture and single write into the status FIFO
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      word_q <= 32'h0000_0000;
      keep_q <= 1'b0;
    end
    else if (state == rxsw_pkg::RXSW_RECV && frame_end_i)
    begin
      word_q <= next_word;
      keep_q <= !runt || pass_bad;
    end
  end

  assign sf.push = (state == rxsw_pkg::RXSW_PUSH) && keep_q;
  assign sf.push_data = word_q;
  assign sf.flush = flush_q;
  assign sf.pop = rd_req && (wb_adr_i == rxsw_pkg::OFS_STAT_PORT);

  // ==========================================================
  // Control register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mac_control_reg <= rxsw_pkg::CTRL_RESET;
    end
    else if (wr_req && wb_adr_i == rxsw_pkg::OFS_CTRL)
    begin
      mac_control_reg <= merge_sel(mac_control_reg, wb_dat_i, wb_sel_i);
    end
  end

  // Dump honoured only while halted, so no word is lost mid-push
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flush_q <= 1'b0;
    end
    else
    begin
      flush_q <= wr_req && wb_adr_i == rxsw_pkg::OFS_DUMP && wb_sel_i[0] &&
                 wb_dat_i[rxsw_pkg::DUMP_BIT] &&
                 state == rxsw_pkg::RXSW_HALTED;
    end
  end

  // Lost word sticky flag; a new loss wins over the clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      overrun <= 1'b0;
    end
    else if (push_blocked)
    begin
      overrun <= 1'b1;
    end
    else if (wr_req && wb_adr_i == rxsw_pkg::OFS_INFO && wb_sel_i[2] &&
             wb_dat_i[rxsw_pkg::INFO_OVR_BIT])
    begin
      overrun <= 1'b0;
    end
  end

  // ==========================================================
  // Wishbone slave: one wait state, unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= bus_req;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else if (rd_req)
    begin
      wb_dat_o <= 32'h0000_0000;
      case (wb_adr_i)
        rxsw_pkg::OFS_CTRL:
        begin
          wb_dat_o <= mac_control_reg;
        end
        rxsw_pkg::OFS_STAT_PORT:
        begin
          // Empty port reads zero rather than a stale word
          wb_dat_o <= sf.empty ? 32'h0000_0000 : sf.head;
        end
        rxsw_pkg::OFS_INFO:
        begin
          wb_dat_o[CNT_W-1:0] <= sf.count;
          wb_dat_o[rxsw_pkg::INFO_HALTED_BIT] <= state == rxsw_pkg::RXSW_HALTED;
          wb_dat_o[rxsw_pkg::INFO_OVR_BIT] <= overrun;
        end
        default:
        begin
          wb_dat_o <= 32'h0000_0000;
        end
      endcase
    end
  end
endmodule : rxsw_builder

// ### bench/rxsw_builder_chk.sv
// Concurrent checks on the status word builder ports
`timescale 1ns/1ps
module rxsw_builder_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic frame_end_i,
  input wire logic rx_gate_o,
  input wire logic receiver_halted_pulse_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic [13:0] len;
  assign len = wb_dat_o[29:16];
  // ==========================================================
  // Bus request and status port read
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence stat_rd_s;
    wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i == rxsw_pkg::OFS_STAT_PORT && !wb_ack_o
      ##1 wb_ack_o;
  endsequence
  // ==========================================================
  // Checks
  a_ack_answers: assert property (req_s |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack missing or too long");
  a_resv_zero: assert property (stat_rd_s |-> wb_dat_o[31] == 1'b0 && wb_dat_o[14] == 1'b0
    && wb_dat_o[9:8] == 2'h0 && wb_dat_o[0] == 1'b0) else $error("reserved bit set");
  a_err_summary: assert property (stat_rd_s |-> wb_dat_o[15] ==
    (wb_dat_o[11] | wb_dat_o[7] | wb_dat_o[6] | wb_dat_o[1])) else $error("summary wrong");
  a_runt_len: assert property (stat_rd_s ##0 len != 14'h0000 |->
    wb_dat_o[11] == (len < 14'h0040)) else $error("runt flag wrong");
  a_too_long: assert property (stat_rd_s |-> wb_dat_o[7] == (len > 14'h05EE))
    else $error("too long flag wrong");
  a_type_short: assert property (stat_rd_s |-> !(wb_dat_o[5] && len < 14'h000E))
    else $error("type flag on short runt");
  a_wdog_len: assert property (stat_rd_s |-> !wb_dat_o[4] || len > 14'h0800)
    else $error("watchdog flag too early");
  a_drib_late: assert property (stat_rd_s |-> !(wb_dat_o[2] && wb_dat_o[6]))
    else $error("dribble with late collision");
  a_halt_single: assert property ($rose(receiver_halted_pulse_o) |=> !receiver_halted_pulse_o)
    else $error("halt pulse too long");
  a_halt_idle: assert property (receiver_halted_pulse_o |-> !rx_gate_o)
    else $error("halt pulse during frame");
  a_gate_drop: assert property (frame_end_i && rx_gate_o |=> !rx_gate_o)
    else $error("gate stays after end");
endmodule : rxsw_builder_chk

bind rxsw_builder rxsw_builder_chk i_rxsw_builder_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frame_end_i(frame_end_i),
  .rx_gate_o(rx_gate_o), .receiver_halted_pulse_o(receiver_halted_pulse_o));

// ### bench/rxsw_host.sv
// Host processor model on the Wishbone register port
`timescale 1ns/1ps
module rxsw_host (
  input wire logic clk_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_i,
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [3:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o
);
  initial
  begin
    {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} = '0;
  end
  // ==========================================================
  // Classic single cycle
  task automatic access(input logic we, input logic [3:0] adr, input logic [31:0] wd,
                        output logic [31:0] rd);
    @(posedge clk_i);
    {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} <= {2'h3, we, adr, 4'hF, wd};
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    rd = wb_dat_i;
    // Released lines carry junk so nothing stale is trusted
    {wb_cyc_o, wb_stb_o} <= 2'h0;
    {wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} <= ~{we, adr, 4'hF, wd};
  endtask : access
  // ==========================================================
  // Receiver stop
  task automatic stop_rx(input logic dump);
    logic [31:0] v;
    access(1'b1, rxsw_pkg::OFS_CTRL, 32'h0, v);
    v = '0;
    while (v[rxsw_pkg::INFO_HALTED_BIT] !== 1'b1) access(1'b0, rxsw_pkg::OFS_INFO, 32'h0, v);
    if (dump) access(1'b1, rxsw_pkg::OFS_DUMP, 32'h1, v);
  endtask : stop_rx
  // ==========================================================
  // Host judgement of a word; bit 1 means nothing on runt, late or watchdog frames
  function automatic logic word_good(input logic [31:0] w);
    return !(w[rxsw_pkg::SW_RUNT] || w[rxsw_pkg::SW_LATE_COL] || w[rxsw_pkg::SW_WDOG]) &&
           !w[rxsw_pkg::SW_CRC_ERR];
  endfunction : word_good
endmodule : rxsw_host

// ### bench/rx_status_word_builder_test.sv
// Self-checking bench for the receive status word builder
`timescale 1ns/1ps
module rx_status_word_builder_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rx_gate_o, receiver_halted_pulse_o;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, v;
  logic frame_start_i = 1'b0, byte_valid_i = 1'b0, rx_er_i = 1'b0, collision_i = 1'b0;
  logic frame_end_i = 1'b0, crc_ok_i = 1'b1, filter_fail_i = 1'b0, mode_10m_i = 1'b0;
  logic [7:0] byte_i = 8'h00;
  logic [2:0] extra_bits_i = 3'h0;
  int mismatches = 0, n_tests = 0, halts = 0, h0;
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) if (receiver_halted_pulse_o === 1'b1) halts <= halts + 1;
  rxsw_builder i_rxsw_builder (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .frame_start_i(frame_start_i), .byte_valid_i(byte_valid_i), .byte_i(byte_i),
    .rx_er_i(rx_er_i), .collision_i(collision_i), .frame_end_i(frame_end_i),
    .crc_ok_i(crc_ok_i), .filter_fail_i(filter_fail_i), .extra_bits_i(extra_bits_i),
    .mode_10m_i(mode_10m_i), .rx_gate_o(rx_gate_o),
    .receiver_halted_pulse_o(receiver_halted_pulse_o));
  rxsw_host i_rxsw_host (.clk_i(clk_i), .wb_dat_i(wb_dat_o), .wb_ack_i(wb_ack_o),
    .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i),
    .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i));
  // ==========================================================
  // Helpers; fl = {rx_er, late collision, bad crc, filter fail}, md = {10M, extra bits}
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  function automatic logic [31:0] expw(logic [47:0] da, logic [15:0] lt, int len,
                                       logic [3:0] fl, logic [3:0] md);
    logic [31:0] w;
    int pl;
    w = '0;
    pl = len - 18;
    w[30] = fl[0];
    w[29:16] = 14'(len);
    w[13] = &da;
    w[12] = len >= 14 && lt <= 16'h05DC && (pl > 46 ? lt != 16'(pl) : lt > 16'h002E);
    w[11] = len < 64;
    w[10] = da[40];
    w[7] = len > 1518;
    w[6] = fl[2];
    w[5] = len >= 14 && lt > 16'h05DC;
    w[4] = len > 2048;
    w[3] = fl[3];
    w[2] = !fl[2] && (md[3] ? md[2:0] >= 3'h3 : md[2:0] >= 3'h4);
    w[1] = fl[1] || fl[3];
    w[15] = w[11] | w[7] | w[6] | w[1];
    return w;
  endfunction : expw
  task automatic send(logic [47:0] da, logic [15:0] lt, int len, logic [3:0] fl, logic [3:0] md);
    @(posedge clk_i);
    frame_start_i <= 1'b1;
    for (int i = 0; i < len; i++)
    begin
      @(posedge clk_i);
      frame_start_i <= 1'b0;
      byte_valid_i <= 1'b1;
      byte_i <= i < 6 ? da[47 - 8 * i -: 8] : i == 12 ? lt[15:8] : i == 13 ? lt[7:0] : 8'(i);
      rx_er_i <= fl[3] && i == 20;
      collision_i <= fl[2] && i == len - 1;
    end
    @(posedge clk_i);
    {byte_valid_i, rx_er_i, collision_i, frame_end_i} <= 4'h1;
    {crc_ok_i, filter_fail_i, mode_10m_i, extra_bits_i} <= {~fl[1], fl[0], md};
    @(posedge clk_i);
    frame_end_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : send
  task automatic frame(logic [47:0] da, logic [15:0] lt, int len, logic [3:0] fl, logic [3:0] md);
    send(da, lt, len, fl, md);
    i_rxsw_host.access(1'b0, rxsw_pkg::OFS_STAT_PORT, 32'h0, v);
    check(v, expw(da, lt, len, fl, md));
    check(32'(i_rxsw_host.word_good(v)), 32'(len > 63 && len < 2049 && !fl[3:1]));
  endtask : frame
  task automatic reg_chk(logic [3:0] adr, logic [31:0] want);
    i_rxsw_host.access(1'b0, adr, 32'h0, v);
    check(v, want);
  endtask : reg_chk
  // ==========================================================
  // Scenarios
  task automatic t_flags;
    frame(48'h0200_0000_0001, 16'h0800, 100, 4'h0, 4'h0);
    frame(48'hFFFF_FFFF_FFFF, 16'h0800, 100, 4'h0, 4'h0);
    frame(48'h0100_5E00_0001, 16'h0800, 100, 4'h0, 4'h0);
    frame(48'h0200_0000_0001, 16'h000A, 100, 4'h0, 4'h0);
    frame(48'h0200_0000_0001, 16'h002E, 64, 4'h0, 4'h0);
    frame(48'h0200_0000_0001, 16'h05DC, 100, 4'h0, 4'h0);
    frame(48'h0200_0000_0001, 16'h0800, 100, 4'h1, 4'h0);
    frame(48'h0200_0000_0001, 16'h0800, 100, 4'h2, 4'h0);
    frame(48'h0200_0000_0001, 16'h0800, 100, 4'h8, 4'h0);
    frame(48'h0200_0000_0001, 16'h0800, 100, 4'h0, 4'h3);
    frame(48'h0200_0000_0001, 16'h0800, 100, 4'h0, 4'h4);
    frame(48'h0200_0000_0001, 16'h0800, 100, 4'h0, 4'hB);
    frame(48'h0200_0000_0001, 16'h0800, 100, 4'h4, 4'h4);
    reg_chk(rxsw_pkg::OFS_STAT_PORT, 32'h0);
    frame(48'h0200_0000_0001, 16'h0800, 1519, 4'h0, 4'h0);
    frame(48'h0200_0000_0001, 16'h0800, 2048, 4'h0, 4'h0);
    frame(48'h0200_0000_0001, 16'h0800, 2049, 4'h0, 4'h0);
    $display("t_flags done");
  endtask : t_flags
  task automatic t_runt;
    send(48'h0200_0000_0001, 16'h0800, 40, 4'h0, 4'h0);
    reg_chk(rxsw_pkg::OFS_STAT_PORT, 32'h0);
    i_rxsw_host.access(1'b1, rxsw_pkg::OFS_CTRL, 32'h0001_0004, v);
    frame(48'h0200_0000_0001, 16'h0800, 40, 4'h0, 4'h0);
    $display("t_runt done");
  endtask : t_runt
  task automatic t_halt;
    send(48'h0200_0000_0001, 16'h0800, 80, 4'h0, 4'h0);
    h0 = halts;
    i_rxsw_host.stop_rx(1'b1);
    repeat (3) @(posedge clk_i);
    check(32'(halts), 32'(h0 + 1));
    send(48'h0200_0000_0001, 16'h0800, 80, 4'h0, 4'h0);
    reg_chk(rxsw_pkg::OFS_INFO, 32'h0001_0000);
    i_rxsw_host.access(1'b1, rxsw_pkg::OFS_CTRL, 32'h4, v);
    frame(48'h0200_0000_0001, 16'h0800, 80, 4'h0, 4'h0);
    $display("t_halt done");
  endtask : t_halt
  // Seventeen frames into sixteen words: oldest kept, loss flagged and cleared
  task automatic t_fill;
    for (int k = 0; k < 17; k++) send(48'h0200_0000_0001, 16'h0800, 64, 4'h0, 4'h0);
    reg_chk(rxsw_pkg::OFS_INFO, 32'h0002_0010);
    i_rxsw_host.access(1'b1, rxsw_pkg::OFS_INFO, 32'h0002_0000, v);
    reg_chk(rxsw_pkg::OFS_INFO, 32'h0000_0010);
    reg_chk(rxsw_pkg::OFS_STAT_PORT, expw(48'h0200_0000_0001, 16'h0800, 64, 4'h0, 4'h0));
    i_rxsw_host.stop_rx(1'b1);
    reg_chk(rxsw_pkg::OFS_INFO, 32'h0001_0000);
    $display("t_fill done");
  endtask : t_fill
  // ==========================================================
  // Sequence and verdict
  task automatic conclude;
    $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    reg_chk(rxsw_pkg::OFS_CTRL, rxsw_pkg::CTRL_RESET);
    reg_chk(rxsw_pkg::OFS_INFO, 32'h0001_0000);
    check(32'(halts), 32'h1);
    i_rxsw_host.access(1'b1, rxsw_pkg::OFS_CTRL, 32'h4, v);
    $display("t_reset done");
    t_flags();
    t_runt();
    t_halt();
    t_fill();
    conclude();
  end
  // Run needs under 10000 cycles
  initial
  begin
    repeat (40000) @(posedge clk_i);
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end
endmodule : rx_status_word_builder_test
